// >>> clkbuf_smbus_pkg.sv
// Shared constants for the clock buffer SMBus target and its host end.
// Assumes both ends run on one 25 MHz core clock with synchronous reset.
package clkbuf_smbus_pkg;

	// ------------------------------------------------------------
	// Bus addressing and command layout
	// ------------------------------------------------------------
	localparam logic [6:0] TARGET_ADDR      = 7'h6C;
	localparam int         CMD_BYTE_BIT     = 7;
	localparam logic [3:0] BIT_ACK          = 4'h8;
	localparam logic [5:0] BLOCK_READ_COUNT = 6'h03;
	localparam logic [5:0] MAX_BLOCK_COUNT  = 6'h20;

	// ------------------------------------------------------------
	// Register indices, field positions and reset values
	// ------------------------------------------------------------
	localparam logic [6:0] IDX_FREQ_PLL     = 7'h00;
	localparam logic [6:0] IDX_OE_LOW       = 7'h01;
	localparam logic [6:0] IDX_OE_HIGH      = 7'h02;
	localparam int         PLL_OVR_LSB      = 1;
	localparam int         PLL_SW_EN_BIT    = 3;
	localparam logic [1:0] PLL_OVR_RESET    = 2'h3;
	localparam logic       PLL_SW_EN_RESET  = 1'h0;
	localparam logic [7:0] OE_RESET         = 8'hFF;
	localparam logic       RSVD_ONE         = 1'h1;
	localparam logic [1:0] RSVD_ZERO2       = 2'h0;
	localparam logic [4:0] RSVD_ZERO5       = 5'h00;
	localparam logic [7:0] UNMAPPED_READ    = 8'h00;

	// PLL mode encoding shared by the readback and override pairs
	typedef enum logic [1:0] {
		pll_low_bandwidth  = 2'h0,
		pll_bypass         = 2'h1,
		pll_high_bandwidth = 2'h3
	} pll_mode_t;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int         CLK_PERIOD_NS    = 40;
	localparam int         SCL_PERIOD_NS    = 10000;
	// Least quarter period, rounded up so the bus never exceeds 100 kHz
	localparam logic [6:0] SCL_QUARTER_CYC  =
		7'((SCL_PERIOD_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// ------------------------------------------------------------
	// Field packing
	// ------------------------------------------------------------
	function automatic logic [7:0] pack_byte0(input logic freq, input logic [1:0] latched,
		input logic sw_en, input logic [1:0] ovr);
		return {latched, RSVD_ZERO2, sw_en, ovr, freq};
	endfunction : pack_byte0

	function automatic logic [7:0] pack_oe_low(input logic [5:0] oe);
		return {oe[5:2], RSVD_ONE, oe[1:0], RSVD_ONE};
	endfunction : pack_oe_low

	function automatic logic [7:0] pack_oe_high(input logic [1:0] oe);
		return {RSVD_ZERO5, oe[1], RSVD_ONE, oe[0]};
	endfunction : pack_oe_high

	function automatic logic count_ok(input logic [7:0] cnt);
		return (cnt != 8'h00) && (cnt <= {2'h0, MAX_BLOCK_COUNT});
	endfunction : count_ok

endpackage : clkbuf_smbus_pkg

// >>> smbus_clock_buffer_control.sv
// SMBus target and control registers of an eight-output clock buffer.
// Assumes SCL/SDA, straps, power-good and OE pins are asynchronous and
// that the host never stretches or glitches SCL faster than 100 kHz.

// ------------------------------------------------------------
// Target end
// ------------------------------------------------------------
module smbus_clock_buffer_control
	import clkbuf_smbus_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       reset,
	input  wire logic       frequency_select_strap,
	input  wire logic [1:0] pll_bandwidth_strap,
	input  wire logic       power_good_input,
	input  wire logic [7:0] output_enable_pin_n,
	output logic      [7:0] differential_clock_output_run,
	output logic      [1:0] pll_mode_select,
	output logic            frequency_select,
	smbus_link_if.device    link
);

	// ------------------------------------------------------------
	// Pin synchronisation
	// ------------------------------------------------------------
	// Bus idles high and OE pins idle deasserted, so no edge fires at reset release
	localparam logic [13:0] SYNC_RESET = {1'h1, 1'h1, 1'h0, 1'h0, 2'h0, 8'hFF};

	typedef enum {st_idle, st_addr, st_cmd, st_count, st_wdata, st_tx} link_state_t;

	logic        scl_s;
	logic        sda_s;
	logic        pg_s;
	logic        freq_s;
	logic [1:0]  bw_s;
	logic [7:0]  oe_pin_n_s;
	logic        scl_d_reg;
	logic        sda_d_reg;
	logic        start_det;
	logic        stop_det;
	logic        scl_rise;
	logic        scl_fall;
	logic        write_allowed;
	logic        reg_write;

	link_state_t state_reg;
	logic [3:0]  bit_cnt_reg;
	logic [7:0]  rx_reg;
	logic [7:0]  tx_reg;
	logic [6:0]  index_reg;
	logic        block_reg;
	logic [5:0]  rem_reg;
	logic        wrote_reg;
	logic        count_pending_reg;
	logic        ack_in_reg;
	logic        sda_drive_reg;

	logic        pg_seen_reg;
	logic        freq_latch_reg;
	logic [1:0]  bw_latch_reg;
	logic        sw_en_reg;
	logic [1:0]  ovr_reg;
	logic [7:0]  oe_reg;

	sync_2ff #(
		.WIDTH       (14),
		.RESET_VALUE (SYNC_RESET)
	) u_pin_sync (
		.core_clk (core_clk),
		.reset    (reset),
		.async_in ({link.scl, link.sda, power_good_input, frequency_select_strap,
			pll_bandwidth_strap, output_enable_pin_n}),
		.sync_out ({scl_s, sda_s, pg_s, freq_s, bw_s, oe_pin_n_s})
	);

	// Delayed copies for edge and condition detection
	always_ff @(posedge core_clk) begin
		if (reset) begin
			scl_d_reg <= 1'h1;
			sda_d_reg <= 1'h1;
		end else begin
			scl_d_reg <= scl_s;
			sda_d_reg <= sda_s;
		end
	end

	// Start, stop and clock edges seen on the synchronised lines
	assign start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
	assign stop_det  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
	assign scl_rise  = scl_s & ~scl_d_reg;
	assign scl_fall  = ~scl_s & scl_d_reg;

	// ------------------------------------------------------------
	// Register readback
	// ------------------------------------------------------------
	// Reserved bits always return their fixed defaults
	function automatic logic [7:0] read_reg(input logic [6:0] idx);
		unique case (idx)
			IDX_FREQ_PLL: return pack_byte0(freq_latch_reg, bw_latch_reg, sw_en_reg, ovr_reg);
			IDX_OE_LOW:   return pack_oe_low(oe_reg[5:0]);
			IDX_OE_HIGH:  return pack_oe_high(oe_reg[7:6]);
			default:      return UNMAPPED_READ;
		endcase
	endfunction : read_reg

	// ------------------------------------------------------------
	// Bus protocol engine
	// ------------------------------------------------------------
	// Byte mode takes one data byte; block mode takes up to the count
	assign write_allowed = block_reg ? (rem_reg != 6'h00) : ~wrote_reg;
	assign reg_write     = pg_s & ~start_det & ~stop_det & scl_fall & (bit_cnt_reg == BIT_ACK)
		& (state_reg == st_wdata) & write_allowed;

	// Bits are taken on SCL rise and driven on SCL fall
	always_ff @(posedge core_clk) begin
		if (reset) begin
			state_reg         <= st_idle;
			bit_cnt_reg       <= 4'h0;
			rx_reg            <= 8'h00;
			tx_reg            <= 8'h00;
			index_reg         <= 7'h00;
			block_reg         <= 1'h0;
			rem_reg           <= 6'h00;
			wrote_reg         <= 1'h0;
			count_pending_reg <= 1'h0;
			ack_in_reg        <= 1'h0;
			sda_drive_reg     <= 1'h0;
		end else if (~pg_s || stop_det) begin
			state_reg     <= st_idle;
			sda_drive_reg <= 1'h0;
		end else if (start_det) begin
			state_reg     <= st_addr;
			bit_cnt_reg   <= 4'h0;
			sda_drive_reg <= 1'h0;
		end else if (state_reg != st_idle) begin
			if (scl_rise) begin
				if (bit_cnt_reg == BIT_ACK) begin
					ack_in_reg  <= ~sda_s;
					bit_cnt_reg <= 4'h0;
				end else begin
					rx_reg      <= {rx_reg[6:0], sda_s};
					bit_cnt_reg <= bit_cnt_reg + 4'h1;
				end
			end
			if (scl_fall) begin
				if (bit_cnt_reg == BIT_ACK) begin
					unique case (state_reg)
						st_idle: begin
						end
						st_addr: begin
							if (rx_reg[7:1] == TARGET_ADDR) begin
								sda_drive_reg <= 1'h1;
								if (rx_reg[0]) begin
									state_reg         <= st_tx;
									// Block read opens with its count
									tx_reg            <= block_reg ? {2'h0, BLOCK_READ_COUNT} : read_reg(index_reg);
									count_pending_reg <= block_reg;
								end else begin
									state_reg <= st_cmd;
								end
							end else begin
								state_reg <= st_idle;
							end
						end
						st_cmd: begin
							sda_drive_reg <= 1'h1;
							block_reg     <= ~rx_reg[CMD_BYTE_BIT];
							index_reg     <= rx_reg[6:0];
							wrote_reg     <= 1'h0;
							state_reg     <= rx_reg[CMD_BYTE_BIT] ? st_wdata : st_count;
						end
						st_count: begin
							sda_drive_reg <= 1'h1;
							rem_reg       <= rx_reg[5:0];
							state_reg     <= st_wdata;
						end
						st_wdata: begin
							// Extra bytes are still acknowledged, just not stored
							sda_drive_reg <= 1'h1;
							if (write_allowed) begin
								index_reg <= index_reg + 7'h01;
								rem_reg   <= rem_reg - 6'h01;
								wrote_reg <= 1'h1;
							end
						end
						st_tx: begin
							sda_drive_reg <= 1'h0; // Host owns the acknowledge bit
							if (count_pending_reg) begin
								count_pending_reg <= 1'h0;
								tx_reg            <= read_reg(index_reg);
							end else begin
								index_reg <= index_reg + 7'h01;
								tx_reg    <= read_reg(index_reg + 7'h01);
							end
						end
					endcase
				end else if (state_reg == st_tx) begin
					// A NAK from the host ends the read
					if ((bit_cnt_reg != 4'h0) || ack_in_reg) begin
						sda_drive_reg <= ~tx_reg[7];
						tx_reg        <= {tx_reg[6:0], 1'h0};
					end else begin
						state_reg     <= st_idle;
						sda_drive_reg <= 1'h0;
					end
				end else begin
					sda_drive_reg <= 1'h0;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------
	// Straps caught once at the first power-good; contents survive power-down
	always_ff @(posedge core_clk) begin
		if (reset) begin
			pg_seen_reg    <= 1'h0;
			freq_latch_reg <= 1'h0;
			bw_latch_reg   <= pll_low_bandwidth;
			sw_en_reg      <= PLL_SW_EN_RESET;
			ovr_reg        <= PLL_OVR_RESET;
			oe_reg         <= OE_RESET;
		end else begin
			if (pg_s && !pg_seen_reg) begin
				pg_seen_reg    <= 1'h1;
				freq_latch_reg <= freq_s;
				bw_latch_reg   <= bw_s;
			end
			if (reg_write) begin
				// Only writable fields are taken from the data byte
				case (index_reg)
					IDX_FREQ_PLL: begin
						sw_en_reg <= rx_reg[PLL_SW_EN_BIT];
						ovr_reg   <= rx_reg[PLL_OVR_LSB +: 2];
					end
					IDX_OE_LOW:  oe_reg[5:0] <= {rx_reg[7:4], rx_reg[2:1]};
					IDX_OE_HIGH: oe_reg[7:6] <= {rx_reg[2], rx_reg[0]};
					default: begin
					end
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// A cleared enable wins over the OE pin; the new mode applies on the next clock
	always_ff @(posedge core_clk) begin
		if (reset) begin
			differential_clock_output_run <= 8'h00;
			pll_mode_select               <= pll_low_bandwidth;
			frequency_select              <= 1'h0;
		end else begin
			differential_clock_output_run <= oe_reg & ~oe_pin_n_s & {8{pg_s}};
			pll_mode_select               <= sw_en_reg ? ovr_reg : bw_latch_reg;
			frequency_select              <= freq_latch_reg;
		end
	end

	assign link.dev_sda_oe  = sda_drive_reg;
	assign link.dev_sda_out = 1'h0;

endmodule : smbus_clock_buffer_control

// >>> smbus_host_end.sv
// SMBus host end issuing byte and block reads and writes to the buffer.
// Assumes a 25 MHz core clock; SCL is generated at 100 kHz from it.
module smbus_host_end
	import clkbuf_smbus_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       reset,
	input  wire logic       cmd_valid,
	input  wire logic       cmd_read,
	input  wire logic       cmd_block,
	input  wire logic [6:0] cmd_index,
	input  wire logic [5:0] cmd_count,
	input  wire logic [7:0] wr_data,
	output logic            cmd_ready,
	output logic            wr_take,
	output logic      [7:0] rd_data,
	output logic            rd_valid,
	output logic            done,
	output logic            ack_error,
	smbus_link_if.host      link
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	typedef enum {h_idle, h_start, h_addr_w, h_cmd, h_count, h_wdata,
		h_rstart, h_addr_r, h_rdata, h_stop} host_state_t;

	host_state_t state_reg;
	logic [6:0]  q_cnt_reg;
	logic [1:0]  phase_reg;
	logic [3:0]  bit_cnt_reg;
	logic [7:0]  tx_reg;
	logic [7:0]  rx_reg;
	logic        read_reg;
	logic        block_reg;
	logic [6:0]  index_reg;
	logic [5:0]  count_reg;
	logic [5:0]  rem_reg;
	logic        count_phase_reg;
	logic        ack_ok_reg;
	logic        sda_s;
	logic        tick;
	logic        scl_lvl;
	logic        sda_lvl;
	logic        last_byte;

	function automatic logic is_byte_state(input host_state_t s);
		return s inside {h_addr_w, h_cmd, h_count, h_wdata, h_addr_r, h_rdata};
	endfunction : is_byte_state

	sync_2ff #(
		.WIDTH       (1),
		.RESET_VALUE (1'h1)
	) u_sda_sync (
		.core_clk (core_clk),
		.reset    (reset),
		.async_in (link.sda),
		.sync_out (sda_s)
	);

	// ------------------------------------------------------------
	// Line levels per quarter of each bit slot
	// ------------------------------------------------------------
	assign tick      = (q_cnt_reg == SCL_QUARTER_CYC - 7'h01);
	// NAK the final byte, or a bad count byte
	assign last_byte = count_phase_reg ? ~count_ok(rx_reg) : (rem_reg == 6'h01);

	always_comb begin
		scl_lvl = 1'h1;
		sda_lvl = 1'h1;
		unique case (state_reg)
			h_idle: begin
			end
			h_start, h_rstart: begin
				scl_lvl = (phase_reg == 2'h1) || (phase_reg == 2'h2);
				sda_lvl = ~phase_reg[1];
			end
			h_stop: begin
				scl_lvl = (phase_reg != 2'h0);
				sda_lvl = phase_reg[1];
			end
			h_addr_w, h_cmd, h_count, h_wdata, h_addr_r, h_rdata: begin
				scl_lvl = (phase_reg == 2'h1) || (phase_reg == 2'h2);
				if (bit_cnt_reg == BIT_ACK) begin
					sda_lvl = (state_reg == h_rdata) ? last_byte : 1'h1;
				end else begin
					sda_lvl = (state_reg == h_rdata) ? 1'h1 : tx_reg[7];
				end
			end
		endcase
	end

	// Pins registered straight from the level decode
	always_ff @(posedge core_clk) begin
		if (reset) begin
			link.host_scl_oe <= 1'h0;
			link.host_sda_oe <= 1'h0;
		end else begin
			link.host_scl_oe <= ~scl_lvl;
			link.host_sda_oe <= ~sda_lvl;
		end
	end

	assign link.host_scl_out = 1'h0;
	assign link.host_sda_out = 1'h0;

	// ------------------------------------------------------------
	// Transfer sequencer
	// ------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (reset) begin
			state_reg       <= h_idle;
			q_cnt_reg       <= 7'h00;
			phase_reg       <= 2'h0;
			bit_cnt_reg     <= 4'h0;
			tx_reg          <= 8'h00;
			rx_reg          <= 8'h00;
			read_reg        <= 1'h0;
			block_reg       <= 1'h0;
			index_reg       <= 7'h00;
			count_reg       <= 6'h00;
			rem_reg         <= 6'h00;
			count_phase_reg <= 1'h0;
			ack_ok_reg      <= 1'h0;
			cmd_ready       <= 1'h1;
			wr_take         <= 1'h0;
			rd_data         <= 8'h00;
			rd_valid        <= 1'h0;
			done            <= 1'h0;
			ack_error       <= 1'h0;
		end else begin
			wr_take  <= 1'h0;
			rd_valid <= 1'h0;
			done     <= 1'h0;
			if (state_reg == h_idle) begin
				q_cnt_reg   <= 7'h00;
				phase_reg   <= 2'h0;
				bit_cnt_reg <= 4'h0;
				if (cmd_valid) begin
					read_reg  <= cmd_read;
					block_reg <= cmd_block;
					index_reg <= cmd_index;
					count_reg <= cmd_count;
					if (cmd_block && !cmd_read && !count_ok({2'h0, cmd_count})) begin
						ack_error <= 1'h1;
						done      <= 1'h1;
					end else begin
						ack_error <= 1'h0;
						cmd_ready <= 1'h0;
						state_reg <= h_start;
					end
				end
			end else begin
				q_cnt_reg <= tick ? 7'h00 : q_cnt_reg + 7'h01;
				if (tick) begin
					phase_reg <= phase_reg + 2'h1;
				end
				// Sample in the middle of SCL high
				if (tick && phase_reg == 2'h1 && is_byte_state(state_reg)) begin
					if (bit_cnt_reg != BIT_ACK) begin
						rx_reg <= {rx_reg[6:0], sda_s};
					end else begin
						ack_ok_reg <= ~sda_s;
					end
				end
				if (tick && phase_reg == 2'h3) begin
					if (is_byte_state(state_reg) && bit_cnt_reg != BIT_ACK) begin
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
						tx_reg      <= {tx_reg[6:0], 1'h0};
					end else if (is_byte_state(state_reg) && state_reg != h_rdata && !ack_ok_reg) begin
						bit_cnt_reg <= 4'h0;
						ack_error   <= 1'h1;
						state_reg   <= h_stop;
					end else begin
						bit_cnt_reg <= 4'h0;
						unique case (state_reg)
							h_idle: begin
							end
							h_start: begin
								state_reg <= h_addr_w;
								tx_reg    <= {TARGET_ADDR, 1'h0};
							end
							h_addr_w: begin
								state_reg <= h_cmd;
								tx_reg    <= {~block_reg, index_reg};
							end
							h_cmd: begin
								if (read_reg) begin
									state_reg <= h_rstart;
								end else if (block_reg) begin
									state_reg <= h_count;
									tx_reg    <= {2'h0, count_reg};
								end else begin
									state_reg <= h_wdata;
									tx_reg    <= wr_data;
									wr_take   <= 1'h1;
									rem_reg   <= 6'h01;
								end
							end
							h_count: begin
								state_reg <= h_wdata;
								tx_reg    <= wr_data;
								wr_take   <= 1'h1;
								rem_reg   <= count_reg;
							end
							h_wdata: begin
								if (rem_reg == 6'h01) begin
									state_reg <= h_stop;
								end else begin
									rem_reg <= rem_reg - 6'h01;
									tx_reg  <= wr_data;
									wr_take <= 1'h1;
								end
							end
							h_rstart: begin
								state_reg <= h_addr_r;
								tx_reg    <= {TARGET_ADDR, 1'h1};
							end
							h_addr_r: begin
								state_reg       <= h_rdata;
								count_phase_reg <= block_reg;
								rem_reg         <= 6'h01;
							end
							h_rdata: begin
								if (count_phase_reg) begin
									count_phase_reg <= 1'h0;
									rem_reg         <= rx_reg[5:0];
									if (!count_ok(rx_reg)) begin
										ack_error <= 1'h1;
										state_reg <= h_stop;
									end
								end else begin
									rd_data  <= rx_reg;
									rd_valid <= 1'h1;
									if (rem_reg == 6'h01) begin
										state_reg <= h_stop;
									end else begin
										rem_reg <= rem_reg - 6'h01;
									end
								end
							end
							h_stop: begin
								state_reg <= h_idle;
								done      <= 1'h1;
								cmd_ready <= 1'h1;
							end
						endcase
					end
				end
			end
		end
	end

endmodule : smbus_host_end

// >>> smbus_link_assertions.sv
// Assertions on the SMBus wires between the host end and the target.
// Assumes it sits beside the link interface in a single clock domain.
module smbus_link_assertions (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic host_sda_oe,
	input wire logic dev_sda_oe,
	input wire logic scl,
	input wire logic sda
);
	timeunit 1ns;
	timeprecision 1ns;
	// ------------------------------------------------------------
	// Wire timing and ownership
	// ------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);
	// Each SCL phase must hold for eight cycles after its edge, so short pulses are caught early
	sequence scl_low_hold; !scl [*8]; endsequence
	sequence scl_high_hold; scl [*8]; endsequence
	bus_idle_a: assert property ($fell(reset) |-> scl && sda && !dev_sda_oe)
		else $error("bus busy after reset");
	scl_low_a: assert property ($fell(scl) |=> scl_low_hold)
		else $error("scl low phase short");
	scl_high_a: assert property ($rose(scl) |=> scl_high_hold)
		else $error("scl high phase short");
	scl_slot_a: assert property ($fell(scl) |-> ##[60:300] $rose(scl))
		else $error("scl stuck low");
	// Target may only turn SDA while SCL is low
	one_talker_a: assert property (scl && dev_sda_oe |-> !host_sda_oe)
		else $error("both ends drive sda");
	sda_hold_a: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
		else $error("target moved sda with scl high");
	ack_hold_a: assert property ($rose(dev_sda_oe) |-> dev_sda_oe [*8])
		else $error("target low bit too short");
	start_host_a: assert property ($fell(sda) && scl |-> host_sda_oe)
		else $error("start not made by host");
endmodule : smbus_link_assertions

// >>> smbus_link_if.sv
// Open-drain SMBus wires between the host end and the clock buffer.
// Assumes each party pulls low only while its enable is high.
interface smbus_link_if;
	logic host_scl_oe;
	logic host_scl_out;
	logic host_sda_oe;
	logic host_sda_out;
	logic dev_sda_oe;
	logic dev_sda_out;
	logic scl;
	logic sda;

	// Wired-AND with pull-ups
	assign scl = ~(host_scl_oe & ~host_scl_out);
	assign sda = ~((host_sda_oe & ~host_sda_out) | (dev_sda_oe & ~dev_sda_out));

	modport host (output host_scl_oe, host_scl_out, host_sda_oe, host_sda_out, input scl, sda);
	modport device (output dev_sda_oe, dev_sda_out, input scl, sda);
endinterface : smbus_link_if

// >>> sync_2ff.sv
// Two-flop synchroniser for asynchronous pins.
// Assumes only the second stage is read by downstream logic.
module sync_2ff #(
	parameter int               WIDTH       = 1,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
	input  wire logic             core_clk,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_reg;

	// First stage feeds only the second
	always_ff @(posedge core_clk) begin
		if (reset) begin
			meta_reg <= RESET_VALUE;
			sync_out <= RESET_VALUE;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule : sync_2ff

// >>> tb_smbus_clock_buffer_control.sv
// Bench joining the host end and the clock buffer target over one link.
// Assumes the checker watches the interface; expectations come from rules.
module tb_smbus_clock_buffer_control import clkbuf_smbus_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 1'h0, reset = 1'h1, freq_strap = 1'h1, power_good = 1'h0;
	logic cmd_valid = 1'h0, cmd_read = 1'h0, cmd_block = 1'h0;
	logic freq_sel, cmd_ready, wr_take, rd_valid, done, ack_error;
	logic [1:0] bw_strap = 2'h0;
	logic [1:0] pll_mode;
	logic [7:0] pin_n = 8'h00, wr_data = 8'h00;
	logic [7:0] run, rd_data;
	logic [6:0] cmd_index = 7'h00;
	logic [5:0] cmd_count = 6'h00;
	logic [7:0] wq[$], rq[$];
	int         error_cnt = 0, comparisons = 0, cycles = 0;
	smbus_link_if link ();
	smbus_clock_buffer_control smbus_clock_buffer_control_inst (.core_clk(core_clk), .reset(reset),
		.frequency_select_strap(freq_strap), .pll_bandwidth_strap(bw_strap), .power_good_input(power_good),
		.output_enable_pin_n(pin_n), .differential_clock_output_run(run), .pll_mode_select(pll_mode),
		.frequency_select(freq_sel), .link(link.device));
	smbus_host_end smbus_host_end_inst (.core_clk(core_clk), .reset(reset), .cmd_valid(cmd_valid),
		.cmd_read(cmd_read), .cmd_block(cmd_block), .cmd_index(cmd_index), .cmd_count(cmd_count),
		.wr_data(wr_data), .cmd_ready(cmd_ready), .wr_take(wr_take), .rd_data(rd_data),
		.rd_valid(rd_valid), .done(done), .ack_error(ack_error), .link(link.host));
	smbus_link_assertions smbus_link_assertions_inst (.core_clk(core_clk), .reset(reset),
		.host_sda_oe(link.host_sda_oe), .dev_sda_oe(link.dev_sda_oe), .scl(link.scl), .sda(link.sda));
	// ------------------------------------------------------------
	// Clock, byte feed and hang guard
	// ------------------------------------------------------------
	initial forever #20 core_clk = ~core_clk;
	// Next write byte is staged once the current one is taken
	always @(posedge core_clk) begin
		// First byte staged at the command edge; the host copies it much later
		if ((wr_take === 1'h1 || cmd_valid === 1'h1) && wq.size() > 0) wr_data <= wq.pop_front();
		if (rd_valid === 1'h1) rq.push_back(rd_data);
		cycles <= cycles + 1;
		// About 87k cycles of traffic, so this ceiling leaves a small margin
		if (cycles == 96000) begin
			error_cnt++;
			end_of_test();
		end
	end
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// One command; the host is idle on the cycle after done
	task automatic cmd(input logic rd, input logic blk, input logic [6:0] idx, input logic [5:0] cnt);
		int n = 0;
		rq.delete();
		cmd_read <= rd;
		cmd_block <= blk;
		cmd_index <= idx;
		cmd_count <= cnt;
		cmd_valid <= 1'h1;
		@(posedge core_clk);
		cmd_valid <= 1'h0;
		do begin
			@(posedge core_clk);
			n++;
		end while (done !== 1'h1 && n < 20000);
		// A command that never finishes is a mismatch and ends the run
		if (done !== 1'h1) begin
			error_cnt++;
			end_of_test();
		end
	endtask : cmd
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : end_of_test
	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		repeat (16) @(posedge core_clk);
		reset <= 1'h0;
		repeat (4) @(posedge core_clk);
		power_good <= 1'h1;
		repeat (8) @(posedge core_clk);
		cmd(1'h1, 1'h1, IDX_FREQ_PLL, 6'h00);
		chk("count", 8'(BLOCK_READ_COUNT), 8'(rq.size()));
		chk("byte0", 8'h07, rq[0]);
		chk("byte1", 8'hFF, rq[1]);
		chk("byte2", 8'h07, rq[2]);
		chk("mode", 8'h00, {6'h00, pll_mode});
		chk("freq", 8'h01, {7'h00, freq_sel});
		$display("test reset values done");
		wq.delete();
		cmd(1'h0, 1'h1, IDX_FREQ_PLL, 6'h00);
		chk("err", 8'h01, {7'h00, ack_error});
		chk("ready", 8'h01, {7'h00, cmd_ready});
		cmd(1'h0, 1'h1, IDX_FREQ_PLL, 6'h21);
		chk("err", 8'h01, {7'h00, ack_error});
		$display("test refused counts done");
		wq = '{8'h00, 8'hFA};
		cmd(1'h0, 1'h1, IDX_OE_LOW, 6'h02);
		chk("err", 8'h00, {7'h00, ack_error});
		wq = '{8'hFF};
		cmd(1'h0, 1'h0, IDX_FREQ_PLL, 6'h00);
		cmd(1'h1, 1'h1, IDX_FREQ_PLL, 6'h00);
		chk("byte0", 8'h0F, rq[0]);
		chk("byte1", 8'h09, rq[1]);
		chk("byte2", 8'h02, rq[2]);
		chk("mode", 8'h03, {6'h00, pll_mode});
		chk("run", 8'h00, run);
		$display("test writes done");
		wq = '{8'h02};
		cmd(1'h0, 1'h0, IDX_OE_LOW, 6'h00);
		repeat (8) @(posedge core_clk);
		chk("run", 8'h01, run);
		pin_n <= 8'h01;
		repeat (8) @(posedge core_clk);
		chk("run", 8'h00, run);
		$display("test enables done");
		wq = '{8'h02};
		cmd(1'h0, 1'h0, IDX_FREQ_PLL, 6'h00);
		cmd(1'h1, 1'h0, IDX_FREQ_PLL, 6'h00);
		chk("byte0", 8'h03, rq[0]);
		chk("mode", 8'h00, {6'h00, pll_mode});
		$display("test strap mode done");
		pin_n <= 8'h00;
		repeat (8) @(posedge core_clk);
		chk("run", 8'h01, run);
		power_good <= 1'h0;
		repeat (8) @(posedge core_clk);
		chk("run", 8'h00, run);
		power_good <= 1'h1;
		repeat (8) @(posedge core_clk);
		cmd(1'h1, 1'h0, IDX_OE_LOW, 6'h00);
		chk("byte1", 8'h0B, rq[0]);
		$display("test power down done");
		end_of_test();
	end
endmodule : tb_smbus_clock_buffer_control
